// file: ssfd_peer.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// External serial device on the far side of the link
module ssfd_peer (
    // Line level and data from the block
    input  wire logic       line_i,
    input  wire logic       sdo_i,
    // Own clock and data towards the block
    output logic            sck_o,
    output logic            sdi_o,
    // Byte to send, bit order, byte taken
    input  wire logic [7:0] tx_i,
    input  wire logic       lsb_i,
    output logic [7:0]      got_o
);
    int   nf = 0;
    int   nr = 0;
    logic sdo_d;

    // Data as it stood just before each clock edge; the block may move it on that edge
    assign #1 sdo_d = sdo_i;

    // Clock stands high outside frames
    initial begin
        sck_o = 1'b1;
        sdi_o = 1'b0;
        got_o = 8'h00;
    end

    // Next bit goes out on each falling edge
    always @(negedge line_i) begin
        sdi_o = tx_i[lsb_i ? nf : 7 - nf];
        nf = (nf + 1) % 8;
    end

    // Bit taken on each rising edge; data scrambled once its hold runs out
    always @(posedge line_i) begin
        got_o[lsb_i ? nr : 7 - nr] = sdo_d;
        nr = (nr + 1) % 8;
        if (nr == 0)
            sdi_o <= #15 ~sdi_o;
    end

    // One byte of clock, 48 ns period
    task automatic frame();
        repeat (8) begin
            #24 sck_o = 1'b0;
            #24 sck_o = 1'b1;
        end
    endtask

    // Realign bit counters after an aborted byte
    task automatic rewind();
        nf = 0;
        nr = 0;
    endtask
endmodule

// file: ssfd_pkg.sv
package ssfd_pkg;

    // Register bus geometry
    localparam int         ADDR_W        = 2;
    localparam int         DATA_W        = 8;

    // Register offsets
    localparam logic [1:0] ADDR_CTRL     = 2'h0;
    localparam logic [1:0] ADDR_STAT     = 2'h1;
    localparam logic [1:0] ADDR_DATA     = 2'h2;

    // Control register fields
    localparam int         CTRL_START    = 7;
    localparam int         CTRL_FSTOP    = 6;
    localparam int         CTRL_MODE_HI  = 5;
    localparam int         CTRL_MODE_LO  = 4;
    localparam int         CTRL_ORDER    = 3;
    localparam int         CTRL_EXTCLK   = 2;

    // Status register fields
    localparam int         STAT_BUSY     = 7;
    localparam int         STAT_CCNT     = 6;
    localparam int         STAT_TXE      = 5;
    localparam int         STAT_RXF      = 4;
    localparam int         STAT_TXU      = 3;
    localparam int         STAT_RXO      = 2;

    // Transfer mode code for full duplex
    localparam logic [1:0] MODE_TXRX     = 2'h2;

    // Reset values
    localparam logic [1:0] MODE_RST      = 2'h0;
    localparam logic       TXE_RST       = 1'b1;
    localparam logic [7:0] BUF_RST       = 8'h00;
    localparam logic       PIN_IDLE      = 1'b1;

    // Bit count of one byte
    localparam logic [3:0] BYTE_BITS     = 4'h8;

    // Internal serial clock half period
    localparam int         CLK_PERIOD_NS = 5;
    localparam int         SCK_HALF_NS   = 40;
    localparam int         SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Shifter phase
    typedef enum logic {
        SSFD_IDLE,
        SSFD_SHIFT
    } ssfd_phase_t;

endpackage

// file: ssfd_serial.sv
`timescale 1ns/100ps

// Summary of operation
// - Full-duplex operation only when the mode field holds code 10.
// - Writing the transmit buffer clears the transmit-empty flag.
// - Busy flag rises at the first serial clock falling edge after start.
// - Transmit bits leave on falling edges in the selected bit order.
// - Receive bits are sampled on rising edges in the same bit order.
// - Clock-count flag is high from the first to the eighth falling edge.
// - Transmit-empty flag sets at the rising edge after the buffer is loaded.
// - After eight bits, receive buffer loads, full flag sets, interrupt fires.
// - Internal clock: load within one serial period, then drive the clock.
// - External clock: load at first falling edge, receive from next rising.
// - Reading the receive buffer clears the receive-full flag.
// - Internal clock parks high until both read and write are done.
// - Wait ends after read and write in any order; resumes within one period.
// - Underrun flag sets when a byte starts without new transmit data.
// - Overrun flag sets when a byte ends while the previous is unread.
// - Clearing start finishes the byte, drops busy, holds data-out high.
// - Forced stop halts at once and resets start, status and both buffers.
// - After underrun, the interrupt waits until all eight bits are received.
// - Data-out stays high during underrun; software reads then forces stop.
// - During overrun new data is discarded; buffer and shifter are kept.
// - Overrun recovery: first read gives last good byte, second the shifter.
// - Clearing the overrun flag also clears the receive-full flag.
module ssfd_serial #(
    parameter int SCK_HALF_CYC = ssfd_pkg::SCK_HALF_CYC
) (
    // Clock and reset
    input  wire logic                         clock_i,
    input  wire logic                         sys_rst_i,
    // Register port
    input  wire logic [ssfd_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [ssfd_pkg::DATA_W-1:0]  reg_wdata_i,
    input  wire logic                         reg_wr_i,
    input  wire logic                         reg_rd_i,
    output logic      [ssfd_pkg::DATA_W-1:0]  reg_rdata_o,
    // Serial pins
    input  wire logic                         serial_clock_pin_i,
    output logic                              serial_clock_pin_o,
    output logic                              serial_clock_pin_oe_o,
    output logic                              serial_data_out_pin_o,
    input  wire logic                         serial_data_in_i,
    // Event output
    output logic                              serial_interrupt_request_o
);
    import ssfd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        ssfd_phase_t phase;
        logic        start;
        logic [1:0]  mode;
        logic        order;
        logic        ext;
        logic        busy;
        logic        ccnt;
        logic        txe;
        logic        rx_buffer_full_flag;
        logic        txu;
        logic        rxo;
        logic [7:0]  txbuf;
        logic [7:0]  rxbuf;
        logic [7:0]  shreg;
        logic [3:0]  cnt;
        logic [7:0]  div;
        logic        sck;
        logic        sdo;
        logic        irq;
        logic [7:0]  rdata;
        logic [2:0]  sck_sy;
        logic [1:0]  sdi_sy;
    } ssfd_state_t;

    ssfd_state_t r;
    ssfd_state_t r_nxt;

    logic       fall;
    logic       rise;
    logic       fstop_wr;
    logic       enabled;
    logic [7:0] sh_in;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Whole block next-state logic
    always_comb begin
        logic int_run;
        logic int_fall;
        logic int_rise;
        logic ext_fall;
        logic ext_rise;
        logic din;
        int_run  = 1'b0;
        int_fall = 1'b0;
        int_rise = 1'b0;
        ext_fall = 1'b0;
        ext_rise = 1'b0;
        din      = 1'b0;
        r_nxt    = r;

        // Pin synchronisers, edges read from the second stage on
        r_nxt.sck_sy = {r.sck_sy[1:0], serial_clock_pin_i};
        r_nxt.sdi_sy = {r.sdi_sy[0], serial_data_in_i};
        r_nxt.irq    = 1'b0;
        r_nxt.rdata  = BUF_RST;
        din          = r.sdi_sy[1];
        ext_fall     = r.ext & r.sck_sy[2] & ~r.sck_sy[1];
        ext_rise     = r.ext & ~r.sck_sy[2] & r.sck_sy[1];
        enabled      = (r.mode == MODE_TXRX);
        fstop_wr     = reg_wr_i & (reg_addr_i == ADDR_CTRL) & reg_wdata_i[CTRL_FSTOP];

        // Internal clock runs mid-byte or once both buffers are serviced
        int_run = ~r.ext & ((r.phase == SSFD_SHIFT) |
                  (r.start & enabled & ~r.txe & ~r.rx_buffer_full_flag));
        if (int_run) begin
            if (r.div == 8'(SCK_HALF_CYC - 1)) begin
                r_nxt.div = 8'h00;
                r_nxt.sck = ~r.sck;
                int_fall  = r.sck;
                int_rise  = ~r.sck;
            end else begin
                r_nxt.div = r.div + 8'h01;
            end
        end else begin
            r_nxt.div = 8'h00;
            r_nxt.sck = PIN_IDLE;
        end
        fall  = int_fall | ext_fall;
        rise  = int_rise | ext_rise;
        sh_in = r.order ? {din, r.shreg[7:1]} : {r.shreg[6:0], din};

        // Register writes and reads; clears come first so sets win
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_CTRL: begin
                    r_nxt.start = reg_wdata_i[CTRL_START];
                    r_nxt.mode  = reg_wdata_i[CTRL_MODE_HI:CTRL_MODE_LO];
                    r_nxt.order = reg_wdata_i[CTRL_ORDER];
                    r_nxt.ext   = reg_wdata_i[CTRL_EXTCLK];
                end
                ADDR_STAT: begin
                    if (!reg_wdata_i[STAT_TXU]) begin
                        r_nxt.txu = 1'b0;
                    end
                    if (!reg_wdata_i[STAT_RXO]) begin
                        r_nxt.rxo = 1'b0;
                        r_nxt.rx_buffer_full_flag = 1'b0;
                    end
                end
                ADDR_DATA: begin
                    r_nxt.txbuf = reg_wdata_i;
                    r_nxt.txe   = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_CTRL: begin
                    r_nxt.rdata = {r.start, 1'b0, r.mode, r.order, r.ext, 2'b00};
                end
                ADDR_STAT: begin
                    r_nxt.rdata = {r.busy, r.ccnt, r.txe, r.rx_buffer_full_flag, r.txu, r.rxo, 2'b00};
                end
                ADDR_DATA: begin
                    // After overrun the second read yields the shifter
                    r_nxt.rdata = (r.rxo & ~r.rx_buffer_full_flag) ? r.shreg : r.rxbuf;
                    r_nxt.rx_buffer_full_flag   = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // Falling edge: byte start or next transmit bit
        if (fall) begin
            if (r.phase == SSFD_IDLE) begin
                if (r.start & enabled) begin
                    r_nxt.phase = SSFD_SHIFT;
                    r_nxt.busy  = 1'b1;
                    r_nxt.ccnt  = 1'b1;
                    r_nxt.cnt   = 4'h1;
                    if (r.txe) begin
                        r_nxt.txu = 1'b1;
                        r_nxt.sdo = PIN_IDLE;
                    end else begin
                        if (!r.rxo) begin
                            r_nxt.shreg = r.txbuf;
                        end
                        r_nxt.sdo = r.order ? r.txbuf[0] : r.txbuf[7];
                    end
                end
            end else begin
                r_nxt.cnt = r.cnt + 4'h1;
                if (r.cnt == BYTE_BITS - 4'h1) begin
                    r_nxt.ccnt = 1'b0;
                end
                r_nxt.sdo = r.txu ? PIN_IDLE : (r.order ? r.shreg[0] : r.shreg[7]);
            end
        end

        // Rising edge: sample one receive bit
        if (rise && r.phase == SSFD_SHIFT) begin
            if (!r.rxo) begin
                r_nxt.shreg = sh_in;
            end
            if (r.cnt == 4'h1) begin
                r_nxt.txe = 1'b1;
            end
            if (r.cnt == BYTE_BITS) begin
                r_nxt.phase = SSFD_IDLE;
                if (r.rx_buffer_full_flag && !r.rxo) begin
                    r_nxt.rxo = 1'b1;
                end else if (!r.rxo) begin
                    r_nxt.rxbuf = sh_in;
                    r_nxt.rx_buffer_full_flag   = 1'b1;
                    r_nxt.irq   = 1'b1;
                end
                if (!r.start) begin
                    r_nxt.busy = 1'b0;
                    r_nxt.sdo  = PIN_IDLE;
                end
            end
        end

        // Forced stop overrides everything but reset
        if (fstop_wr) begin
            r_nxt.start = 1'b0;
            r_nxt.phase = SSFD_IDLE;
            r_nxt.busy  = 1'b0;
            r_nxt.ccnt  = 1'b0;
            r_nxt.txe   = TXE_RST;
            r_nxt.rx_buffer_full_flag   = 1'b0;
            r_nxt.txu   = 1'b0;
            r_nxt.rxo   = 1'b0;
            r_nxt.txbuf = BUF_RST;
            r_nxt.rxbuf = BUF_RST;
            r_nxt.cnt   = 4'h0;
            r_nxt.div   = 8'h00;
            r_nxt.sck   = PIN_IDLE;
            r_nxt.sdo   = PIN_IDLE;
            r_nxt.irq   = 1'b0;
        end

        // Synchronous reset
        if (sys_rst_i) begin
            r_nxt        = '0;
            r_nxt.phase  = SSFD_IDLE;
            r_nxt.mode   = MODE_RST;
            r_nxt.txe    = TXE_RST;
            r_nxt.sck    = PIN_IDLE;
            r_nxt.sdo    = PIN_IDLE;
            r_nxt.sck_sy = {3{PIN_IDLE}};
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        r <= r_nxt;
    end

    // Outputs
    assign reg_rdata_o                = r.rdata;
    assign serial_clock_pin_o         = r.sck;
    assign serial_clock_pin_oe_o      = ~r.ext;
    assign serial_data_out_pin_o      = r.sdo;
    assign serial_interrupt_request_o = r.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    property p_txe_clr;
        (reg_wr_i && reg_addr_i == ADDR_DATA && !(rise && r.cnt == 4'h1)) |=> !r.txe;
    endproperty
    a_txe_clr: assert property (p_txe_clr) else $error("tx empty not cleared");

    property p_start;
        (fall && r.phase == SSFD_IDLE && r.start && enabled && !fstop_wr)
            |=> (r.busy && r.ccnt && r.cnt == 4'h1 && r.txu == $past(r.txe));
    endproperty
    a_start: assert property (p_start) else $error("byte start wrong");

    property p_ccnt_end;
        (fall && r.phase == SSFD_SHIFT && r.cnt == 4'h7 && !fstop_wr) |=> !r.ccnt;
    endproperty
    a_ccnt_end: assert property (p_ccnt_end) else $error("count flag not cleared");

    property p_txe_set;
        (rise && r.phase == SSFD_SHIFT && r.cnt == 4'h1 && !fstop_wr) |=> r.txe;
    endproperty
    a_txe_set: assert property (p_txe_set) else $error("tx empty not set");

    property p_rx_copy;
        (rise && r.phase == SSFD_SHIFT && r.cnt == BYTE_BITS && !r.rxo && !r.rx_buffer_full_flag && !fstop_wr)
            |=> (r.rx_buffer_full_flag && serial_interrupt_request_o && r.rxbuf == $past(sh_in))
            ##1 !serial_interrupt_request_o;
    endproperty
    a_rx_copy: assert property (p_rx_copy) else $error("receive copy wrong");

    property p_rd_clr;
        (reg_rd_i && reg_addr_i == ADDR_DATA && !(rise && r.cnt == BYTE_BITS)) |=> !r.rx_buffer_full_flag;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("rx full not cleared");

    property p_park;
        (!r.ext && r.phase == SSFD_IDLE && (r.rx_buffer_full_flag || r.txe)) |=> serial_clock_pin_o;
    endproperty
    a_park: assert property (p_park) else $error("clock not parked");

    property p_stop;
        (rise && r.phase == SSFD_SHIFT && r.cnt == BYTE_BITS && !r.start && !reg_wr_i)
            |=> (!r.busy && serial_data_out_pin_o);
    endproperty
    a_stop: assert property (p_stop) else $error("stop not orderly");

    property p_fstop;
        fstop_wr |=> (!r.start && !r.busy && r.txe && !r.rx_buffer_full_flag && r.rxbuf == BUF_RST);
    endproperty
    a_fstop: assert property (p_fstop) else $error("forced stop incomplete");

    property p_txu_sdo;
        r.txu |-> serial_data_out_pin_o;
    endproperty
    a_txu_sdo: assert property (p_txu_sdo) else $error("data out not high");

    property p_rxo_hold;
        (r.rxo && rise && !fstop_wr) |=> (r.shreg == $past(r.shreg) && r.rxbuf == $past(r.rxbuf));
    endproperty
    a_rxo_hold: assert property (p_rxo_hold) else $error("overrun data lost");

endmodule

// file: ssfd_tb.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module testbench;
    import ssfd_pkg::*;

    logic        clock_i    = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic [1:0]  addr       = 2'h0;
    logic [7:0]  wdata      = 8'h00;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic        lsb        = 1'b0;
    logic [7:0]  ptx        = 8'h00;
    logic [31:0] seed       = 32'hE803;
    logic [7:0]  rdata, got, b;
    logic        sck_o, sck_oe, sdo, irq, p_sck, sdi;
    logic [7:0]  q[$];
    logic [7:0]  t[$];
    int          failures   = 0;
    int          n_compared = 0;
    wire         line       = sck_oe ? sck_o : p_sck;

    // System clock, 200 MHz
    always #2.5 clock_i = ~clock_i;

    ssfd_serial dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .serial_clock_pin_i(line), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_o(sck_oe), .serial_data_out_pin_o(sdo),
        .serial_data_in_i(sdi), .serial_interrupt_request_o(irq)
    );

    ssfd_peer peer (
        .line_i(line), .sdo_i(sdo), .sck_o(p_sck), .sdi_o(sdi),
        .tx_i(ptx), .lsb_i(lsb), .got_o(got)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers: random bytes, bus cycles, compares
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic wrap_up();
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr    <= 1'b0;
    endtask

    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd   <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clock_i);
            #1;
            n++;
            if (n > 400) begin
                failures++;
                wrap_up();
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        peer.rewind();
        rchk(ADDR_STAT, 8'h20);
        rchk(ADDR_CTRL, 8'h00);
        rchk(2'h3, 8'h00);
        // Internal clock, both bit orders, three bytes each
        for (int o = 0; o < 2; o++) begin
            lsb <= o[0];
            ptx <= rnd();
            b = rnd();
            t.push_back(b);
            wreg(ADDR_DATA, b);
            rchk(ADDR_STAT, 8'h00);
            wreg(ADDR_CTRL, {4'hA, o[0], 3'h0});
            repeat (30) @(posedge clock_i);
            rchk(ADDR_STAT, 8'hE0);
            for (int i = 0; i < 3; i++) begin
                q.push_back(ptx);
                wait_irq();
                rchk(ADDR_STAT, i == 2 ? 8'h30 : 8'hB0);
                chk(got, t.pop_front());
                if (i == 2)
                    break;
                ptx <= rnd();
                b = rnd();
                t.push_back(b);
                if (i == 0)
                    rchk(ADDR_DATA, q.pop_front());
                else
                    wreg(ADDR_DATA, b);
                repeat (40) @(posedge clock_i);
                #1;
                chk({7'h0, sck_o}, 8'h01);
                if (i == 0)
                    wreg(ADDR_DATA, b);
                else
                    rchk(ADDR_DATA, q.pop_front());
                if (i == 1) begin
                    repeat (40) @(posedge clock_i);
                    wreg(ADDR_CTRL, {4'h2, o[0], 3'h0});
                end
            end
            chk({7'h0, sdo}, 8'h01);
            rchk(ADDR_DATA, q.pop_front());
            wreg(ADDR_CTRL, 8'h40);
        end
        lsb <= 1'b0;
        // Mode code 01 starts nothing; forced stop in mid byte
        wreg(ADDR_DATA, rnd());
        wreg(ADDR_CTRL, 8'h90);
        repeat (40) @(posedge clock_i);
        rchk(ADDR_STAT, 8'h00);
        wreg(ADDR_CTRL, 8'hA0);
        repeat (40) @(posedge clock_i);
        wreg(ADDR_CTRL, 8'h60);
        rchk(ADDR_STAT, 8'h20);
        peer.rewind();
        rchk(ADDR_DATA, 8'h00);
        rchk(ADDR_CTRL, 8'h20);
        chk({5'h0, sck_oe, sck_o, sdo}, 8'h07);
        // External clock, no transmit byte: underrun
        ptx <= rnd();
        wreg(ADDR_CTRL, 8'hA4);
        peer.frame();
        chk({7'h0, sck_oe}, 8'h00);
        wait_irq();
        rchk(ADDR_STAT, 8'hB8);
        chk(got, 8'hFF);
        rchk(ADDR_DATA, ptx);
        wreg(ADDR_CTRL, 8'h64);
        rchk(ADDR_STAT, 8'h20);
        // External clock, first byte left unread: overrun
        wreg(ADDR_CTRL, 8'hA4);
        b = rnd();
        ptx <= rnd();
        wreg(ADDR_DATA, b);
        q.push_back(ptx);
        peer.frame();
        wait_irq();
        chk(got, b);
        ptx <= rnd();
        wreg(ADDR_DATA, rnd());
        q.push_back(ptx);
        fork
            peer.frame();
            begin
                #100;
                wreg(ADDR_CTRL, 8'h24);
            end
        join
        repeat (10) @(posedge clock_i);
        rchk(ADDR_STAT, 8'h34);
        rchk(ADDR_DATA, q.pop_front());
        rchk(ADDR_DATA, q.pop_front());
        rchk(ADDR_STAT, 8'h24);
        wreg(ADDR_STAT, 8'h00);
        rchk(ADDR_STAT, 8'h20);
        wrap_up();
    end
endmodule
